// *** design/inprot_pkg.sv ***
package inprot_pkg;
    localparam int DATA_W = 16;
    localparam int MAN_W = 11;
    localparam logic [7:0] CMD_OPERATION = 8'h01;
    localparam logic [7:0] CMD_RESTORE = 8'h12;
    localparam logic [7:0] CMD_ALERT_MASK = 8'h1b;
    localparam logic [7:0] CMD_TURN_ON = 8'h35;
    localparam logic [7:0] CMD_OV_LIMIT = 8'h55;
    localparam logic [7:0] CMD_OV_ACTION = 8'h56;
    localparam logic [7:0] CMD_UV_LIMIT = 8'h59;
    localparam logic [7:0] CMD_UV_ACTION = 8'h5a;
    localparam logic [7:0] CMD_OC_LIMIT = 8'h5b;
    localparam logic [7:0] CMD_OC_ACTION = 8'h5c;
    localparam logic [7:0] CMD_OCW_LIMIT = 8'h5d;
    localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
    localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
    localparam logic [7:0] CMD_STATUS_INPUT = 8'h7c;
    localparam logic [4:0] EXP_QUARTER = 5'h1e;
    localparam logic [4:0] EXP_HALF = 5'h1f;
    localparam logic [4:0] EXP_UNIT = 5'h00;
    localparam logic [7:0] ACT_OV = 8'h00;
    localparam logic [7:0] ACT_UV = 8'hc0;
    localparam logic [7:0] ACT_OC = 8'hc0;
    localparam logic [15:0] CUR_DEFAULT = 16'hf87f;
    localparam logic [7:0] CUR_HIGH = 8'hf8;
    localparam logic [3:0] CUR_STEP_LOW = 4'h1;
    localparam logic [3:0] CUR_STEP_HIGH = 4'h7;
    localparam int SI_OV = 7;
    localparam int SI_UV = 4;
    localparam int SI_OC = 2;
    localparam int SI_OCW = 1;
    localparam int SB_OTHER = 0;
    localparam int SW_INPUT = 13;
    localparam int OP_ON = 7;
    localparam logic [7:0] OP_RESET = 8'h80;
    localparam logic [7:0] MASK_RESET = 8'h00;

    // only a few stored current codes survive a reload
    function automatic logic [15:0] restore_current(input logic [15:0] v);
        if (v == CUR_DEFAULT) begin
            return v;
        end
        if (v[15:8] == CUR_HIGH && v[3:0] == 4'h0 && v[7:4] >= CUR_STEP_LOW
            && v[7:4] <= CUR_STEP_HIGH) begin
            return v;
        end
        return CUR_DEFAULT;
    endfunction : restore_current
endpackage : inprot_pkg

// *** design/xfer_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface xfer_if;
    logic req_tgl;
    logic [7:0] cmd;
    logic wr;
    logic word;
    logic [15:0] wdata;
    logic ack_tgl;
    logic [15:0] rdata;
    logic err;
    modport link (output req_tgl, cmd, wr, word, wdata, input ack_tgl, rdata, err);
    modport core (input req_tgl, cmd, wr, word, wdata, output ack_tgl, rdata, err);
endinterface : xfer_if
`default_nettype wire

// *** design/link_port.sv ***
`timescale 1ns/10ps
`default_nettype none
module link_port (
    // link clock and core reset
    input wire logic link_clk_in,
    input wire logic rst_in,
    // command side
    input wire logic link_req_in,
    input wire logic [7:0] link_cmd_in,
    input wire logic link_write_in,
    input wire logic link_word_in,
    input wire logic [15:0] link_wdata_in,
    output logic link_done_out,
    output logic link_busy_out,
    output logic [15:0] link_rdata_out,
    output logic link_err_out,
    // toward the core domain
    xfer_if.link x
);
    typedef enum logic {IDLE, WAIT} lstate_t;
    typedef struct packed {
        logic [1:0] rst_s;
        lstate_t st;
        logic req_tgl;
        logic [1:0] ack_s;
        logic ack_seen;
        logic [7:0] cmd;
        logic wr;
        logic word;
        logic [15:0] wdata;
        logic done;
        logic busy;
        logic [15:0] rdata;
        logic err;
    } link_t;
    link_t q, d;

    always_comb begin
        d = q;
        d.rst_s = {q.rst_s[0], rst_in};
        d.ack_s = {q.ack_s[0], x.ack_tgl};
        d.done = 1'b0;
        unique case (q.st)
            IDLE: begin
                // command words held still until the core answers
                if (link_req_in) begin
                    d.cmd = link_cmd_in;
                    d.wr = link_write_in;
                    d.word = link_word_in;
                    d.wdata = link_wdata_in;
                    d.req_tgl = ~q.req_tgl;
                    d.st = WAIT;
                end
            end
            WAIT: begin
                if (q.ack_s[1] != q.ack_seen) begin
                    d.ack_seen = q.ack_s[1];
                    d.rdata = x.rdata;
                    d.err = x.err;
                    d.done = 1'b1;
                    d.st = IDLE;
                end
            end
        endcase
        d.busy = (d.st == WAIT);
        if (q.rst_s[1]) begin
            d = '0;
            d.rst_s = {q.rst_s[0], rst_in};
            d.ack_s = {q.ack_s[0], x.ack_tgl};
            d.st = IDLE;
        end
    end

    always_ff @(posedge link_clk_in) begin
        q <= d;
    end

    assign x.req_tgl = q.req_tgl;
    assign x.cmd = q.cmd;
    assign x.wr = q.wr;
    assign x.word = q.word;
    assign x.wdata = q.wdata;
    assign link_done_out = q.done;
    assign link_busy_out = q.busy;
    assign link_rdata_out = q.rdata;
    assign link_err_out = q.err;

    a_done_one_pulse: assert property (@(posedge link_clk_in) disable iff (q.rst_s[1])
        link_done_out |=> !link_done_out && (!link_busy_out || $past(link_req_in)))
        else $error("answer strobe longer than one cycle");
endmodule : link_port
`default_nettype wire

// *** design/input_protect_regs.sv ***
// Notes on behaviour
// - turn-on threshold: fixed exponent -2, writable mantissa loaded from storage
// - only listed turn-on codes 4.0 V to 11.25 V are meant to be used
// - all commands here are one shared copy, no page selection
// - overvoltage limit: fixed exponent 0, 1 V steps, mantissa 0..31; the code stores and compares all 11 mantissa bits
// - overvoltage only reported, conversion goes on; action reads 00h
// - overvoltage sets other, input and overvoltage-fault status bits
// - every input event raises host alert unless its mask bit is set
// - undervoltage ignored until input passed turn-on once while enabled
// - undervoltage limit fully writable, listed codes 4.25 V to 11.5 V
// - undervoltage stops conversion, restarts when cleared; action reads C0h
// - undervoltage sets other, input and undervoltage-fault status bits
// - current limits: fixed exponent -1, 0.5 A steps, mantissa 0..127; the code stores and compares all 11 mantissa bits
// - current limits reload only from listed codes, otherwise 63.5 A
// - current warning sets other, input and current-warning status bits
// - current fault latches off, sets status, raises alert and fault pin
// - limits take word access, action commands take byte reads only
// - no conversion until input reaches the turn-on threshold
// - latched current fault cleared by toggling enable or the on bit
`timescale 1ns/10ps
`default_nettype none
module input_protect_regs (
    // clocks and reset
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic link_clk_in,
    // command link
    input wire logic link_req_in,
    input wire logic [7:0] link_cmd_in,
    input wire logic link_write_in,
    input wire logic link_word_in,
    input wire logic [inprot_pkg::DATA_W-1:0] link_wdata_in,
    output logic link_done_out,
    output logic link_busy_out,
    output logic [inprot_pkg::DATA_W-1:0] link_rdata_out,
    output logic link_err_out,
    // stored defaults
    input wire logic [inprot_pkg::DATA_W-1:0] nvm_turn_on_in,
    input wire logic [inprot_pkg::DATA_W-1:0] nvm_ov_limit_in,
    input wire logic [inprot_pkg::DATA_W-1:0] nvm_uv_limit_in,
    input wire logic [inprot_pkg::DATA_W-1:0] nvm_oc_limit_in,
    input wire logic [inprot_pkg::DATA_W-1:0] nvm_ocw_limit_in,
    // telemetry
    input wire logic telem_valid_in,
    input wire logic [inprot_pkg::DATA_W-1:0] vin_quarter_in,
    input wire logic [inprot_pkg::DATA_W-1:0] iin_half_in,
    // pins
    input wire logic channel_enable_pin_in,
    output logic host_alert_pin_out,
    output logic host_alert_pin_oe_out,
    output logic regulator_fault_pin_out,
    output logic conversion_on_out
);
    import inprot_pkg::*;

    typedef struct packed {
        logic [1:0] req_s;
        logic req_seen;
        logic ack_tgl;
        logic [DATA_W-1:0] rdata;
        logic err;
        logic [MAN_W-1:0] von_man;
        logic [MAN_W-1:0] ov_man;
        logic [DATA_W-1:0] uv_lim;
        logic [MAN_W-1:0] oc_man;
        logic [MAN_W-1:0] ocw_man;
        logic [7:0] op;
        logic [7:0] mask;
        logic [7:0] st;
        logic [1:0] en_s;
        logic en_prev;
        logic vin_ok;
        logic armed;
        logic uv_act;
        logic oc_latch;
        logic conv;
        logic alert;
        logic od_low;
        logic vrf;
    } core_t;

    core_t q, d;
    xfer_if x ();

    logic new_req;
    logic en;
    logic load;
    logic [7:0] set;
    logic [7:0] clr;
    logic [DATA_W-1:0] von_q;
    logic [DATA_W-1:0] ov_q;
    logic [DATA_W-1:0] uv_q;
    logic [DATA_W-1:0] oc_q;
    logic [DATA_W-1:0] ocw_q;
    logic [DATA_W-1:0] oc_restored;
    logic [DATA_W-1:0] ocw_restored;
    logic [DATA_W-1:0] sw;

    link_port u_link (
        .link_clk_in(link_clk_in),
        .rst_in(rst_in),
        .link_req_in(link_req_in),
        .link_cmd_in(link_cmd_in),
        .link_write_in(link_write_in),
        .link_word_in(link_word_in),
        .link_wdata_in(link_wdata_in),
        .link_done_out(link_done_out),
        .link_busy_out(link_busy_out),
        .link_rdata_out(link_rdata_out),
        .link_err_out(link_err_out),
        .x(x)
    );

    // undervoltage limit in quarter volts; exponent picks the step
    function automatic logic [DATA_W-1:0] uv_quarter(input logic [DATA_W-1:0] lim);
        case (lim[DATA_W-1:MAN_W])
            EXP_QUARTER: return {5'h00, lim[MAN_W-1:0]};
            EXP_HALF: return {4'h0, lim[MAN_W-1:0], 1'b0};
            default: return {3'h0, lim[MAN_W-1:0], 2'b00};
        endcase
    endfunction : uv_quarter

    assign oc_restored = restore_current(nvm_oc_limit_in);
    assign ocw_restored = restore_current(nvm_ocw_limit_in);
    assign von_q = {5'h00, q.von_man};
    assign ov_q = {3'h0, q.ov_man, 2'b00};
    assign uv_q = uv_quarter(q.uv_lim);
    assign oc_q = {5'h00, q.oc_man};
    assign ocw_q = {5'h00, q.ocw_man};

    always_comb begin
        d = q;
        set = '0;
        clr = '0;
        load = 1'b0;
        sw = '0;
        sw[SB_OTHER] = |q.st;
        sw[SW_INPUT] = |q.st;
        d.req_s = {q.req_s[0], x.req_tgl};
        d.en_s = {q.en_s[0], channel_enable_pin_in};
        new_req = q.req_s[1] ^ q.req_seen;
        en = q.en_s[1] & q.op[OP_ON];
        d.en_prev = en;
        // fresh comparison on every telemetry sample
        if (telem_valid_in) begin
            d.vin_ok = vin_quarter_in >= von_q;
            set[SI_OV] = vin_quarter_in > ov_q;
            d.uv_act = q.armed && (vin_quarter_in < uv_q);
            set[SI_UV] = d.uv_act;
            set[SI_OCW] = iin_half_in > ocw_q;
            set[SI_OC] = iin_half_in > oc_q;
            if (d.vin_ok && en) begin
                d.armed = 1'b1;
            end
        end
        // latch holds until enable drops, pin or on bit
        if (set[SI_OC]) begin
            d.oc_latch = 1'b1;
        end else if (q.en_prev && !en) begin
            d.oc_latch = 1'b0;
        end
        // one shared copy, there is no page selection here
        if (new_req) begin
            d.req_seen = q.req_s[1];
            d.ack_tgl = ~q.ack_tgl;
            d.err = 1'b0;
            d.rdata = '0;
            case (x.cmd)
                CMD_TURN_ON: begin
                    d.err = !x.word;
                    d.rdata = {EXP_QUARTER, q.von_man};
                    if (x.wr && x.word) begin
                        d.von_man = x.wdata[MAN_W-1:0];
                    end
                end
                CMD_OV_LIMIT: begin
                    d.err = !x.word;
                    d.rdata = {EXP_UNIT, q.ov_man};
                    if (x.wr && x.word) begin
                        d.ov_man = x.wdata[MAN_W-1:0];
                    end
                end
                CMD_UV_LIMIT: begin
                    d.err = !x.word;
                    d.rdata = q.uv_lim;
                    if (x.wr && x.word) begin
                        d.uv_lim = x.wdata;
                    end
                end
                CMD_OC_LIMIT: begin
                    d.err = !x.word;
                    d.rdata = {EXP_HALF, q.oc_man};
                    if (x.wr && x.word) begin
                        d.oc_man = x.wdata[MAN_W-1:0];
                    end
                end
                CMD_OCW_LIMIT: begin
                    d.err = !x.word;
                    d.rdata = {EXP_HALF, q.ocw_man};
                    if (x.wr && x.word) begin
                        d.ocw_man = x.wdata[MAN_W-1:0];
                    end
                end
                CMD_OV_ACTION: begin
                    d.err = x.wr || x.word;
                    d.rdata = {8'h00, ACT_OV};
                end
                CMD_UV_ACTION: begin
                    d.err = x.wr || x.word;
                    d.rdata = {8'h00, ACT_UV};
                end
                CMD_OC_ACTION: begin
                    d.err = x.wr || x.word;
                    d.rdata = {8'h00, ACT_OC};
                end
                CMD_ALERT_MASK: begin
                    d.err = x.word;
                    d.rdata = {8'h00, q.mask};
                    if (x.wr && !x.word) begin
                        d.mask = x.wdata[7:0];
                    end
                end
                CMD_OPERATION: begin
                    d.err = x.word;
                    d.rdata = {8'h00, q.op};
                    if (x.wr && !x.word) begin
                        d.op = x.wdata[7:0];
                    end
                end
                CMD_STATUS_INPUT: begin
                    d.err = x.word;
                    d.rdata = {8'h00, q.st};
                    if (x.wr && !x.word) begin
                        clr = x.wdata[7:0];
                    end
                end
                CMD_STATUS_BYTE: begin
                    d.err = x.wr || x.word;
                    d.rdata = {8'h00, sw[7:0]};
                end
                CMD_STATUS_WORD: begin
                    d.err = x.wr || !x.word;
                    d.rdata = sw;
                end
                CMD_RESTORE: begin
                    d.err = !x.wr;
                    load = x.wr;
                end
                default: begin
                    d.err = 1'b1;
                end
            endcase
        end
        if (load) begin
            d.von_man = nvm_turn_on_in[MAN_W-1:0];
            d.ov_man = nvm_ov_limit_in[MAN_W-1:0];
            d.uv_lim = nvm_uv_limit_in;
            d.oc_man = oc_restored[MAN_W-1:0];
            d.ocw_man = ocw_restored[MAN_W-1:0];
        end
        // an event in the clearing cycle still lands
        d.st = (q.st & ~clr) | set;
        // overvoltage has no say in conversion
        d.conv = en & q.vin_ok & ~q.uv_act & ~q.oc_latch;
        d.alert = |(q.st & ~q.mask);
        d.vrf = q.st[SI_OC] & ~q.mask[SI_OC];
        d.od_low = 1'b0;
        if (rst_in) begin
            d = '0;
            d.op = OP_RESET;
            d.mask = MASK_RESET;
            d.von_man = nvm_turn_on_in[MAN_W-1:0];
            d.ov_man = nvm_ov_limit_in[MAN_W-1:0];
            d.uv_lim = nvm_uv_limit_in;
            d.oc_man = oc_restored[MAN_W-1:0];
            d.ocw_man = ocw_restored[MAN_W-1:0];
        end
    end

    always_ff @(posedge clk_in) begin
        q <= d;
    end

    assign x.ack_tgl = q.ack_tgl;
    assign x.rdata = q.rdata;
    assign x.err = q.err;
    assign host_alert_pin_out = q.od_low;
    assign host_alert_pin_oe_out = q.alert;
    assign regulator_fault_pin_out = q.vrf;
    assign conversion_on_out = q.conv;

    a_ov_sets_status: assert property (@(posedge clk_in) disable iff (rst_in)
        telem_valid_in && vin_quarter_in > ov_q |=> q.st[SI_OV] && sw[SW_INPUT])
        else $error("overvoltage did not set status");

    a_ov_keeps_power: assert property (@(posedge clk_in) disable iff (rst_in)
        q.conv && en && q.vin_ok && !q.uv_act && !q.oc_latch |=> conversion_on_out)
        else $error("conversion dropped without cause");

    a_oc_latches_off: assert property (@(posedge clk_in) disable iff (rst_in)
        telem_valid_in && iin_half_in > oc_q |=> q.oc_latch ##1 !conversion_on_out)
        else $error("current fault did not latch off");

    a_alert_unmasked: assert property (@(posedge clk_in) disable iff (rst_in)
        telem_valid_in && iin_half_in > ocw_q && !q.mask[SI_OCW] && !clr[SI_OCW]
        ##1 !q.mask[SI_OCW] |=> host_alert_pin_oe_out)
        else $error("unmasked event raised no alert");

    a_alert_all_masked: assert property (@(posedge clk_in) disable iff (rst_in)
        (q.mask == 8'hff) [*2] |-> !host_alert_pin_oe_out && !regulator_fault_pin_out)
        else $error("alert raised while masked");

    a_uv_needs_arming: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(q.st[SI_UV]) |-> $past(q.armed))
        else $error("undervoltage flagged before arming");

    a_conv_needs_vin: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(conversion_on_out) |-> $past(q.vin_ok) && !$past(q.uv_act))
        else $error("conversion started below threshold");

    a_set_beats_clear: assert property (@(posedge clk_in) disable iff (rst_in)
        set[SI_OV] && clr[SI_OV] |=> q.st[SI_OV])
        else $error("clear swallowed an event");

    a_action_byte_only: assert property (@(posedge clk_in) disable iff (rst_in)
        new_req && x.cmd == CMD_UV_ACTION && (x.wr || x.word) |=> q.err)
        else $error("wrong size action access accepted");

    a_current_reload: assert property (@(posedge clk_in) disable iff (rst_in)
        $past(rst_in) || $past(load) |-> restore_current({EXP_HALF, q.oc_man})
        == {EXP_HALF, q.oc_man})
        else $error("current limit reloaded to unlisted code");
endmodule : input_protect_regs
`default_nettype wire

// *** tb/host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module host_model (
    // link clock
    input wire logic clk_in,
    // answers from the device
    input wire logic busy_in,
    input wire logic done_in,
    input wire logic [15:0] rdata_in,
    input wire logic err_in,
    // requests to the device
    output logic req_out,
    output logic [7:0] cmd_out,
    output logic write_out,
    output logic word_out,
    output logic [15:0] wdata_out
);
    initial begin
        req_out = 1'b0;
        cmd_out = 8'h00;
        write_out = 1'b0;
        word_out = 1'b0;
        wdata_out = 16'h0000;
    end

    // word for limits, byte for actions
    task automatic xfer(input logic [7:0] c, input logic w, input logic wd,
            input logic [15:0] d, output logic [15:0] q, output logic e, output bit ok);
        int n;
        n = 0;
        @(posedge clk_in);
        #1;
        while (busy_in !== 1'b0 && n < 20) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        ok = (n < 20);
        req_out <= 1'b1;
        cmd_out <= c;
        write_out <= w;
        word_out <= wd;
        wdata_out <= d;
        @(posedge clk_in);
        req_out <= 1'b0;
        // released lines show no stale value
        cmd_out <= ~c;
        wdata_out <= ~d;
        n = 0;
        do begin
            @(posedge clk_in);
            #1;
            n++;
        end while (done_in !== 1'b1 && n < 20);
        q = rdata_in;
        e = err_in;
        ok = ok && (done_in === 1'b1);
    endtask : xfer
endmodule : host_model
`default_nettype wire

// *** tb/test_input_protect_regs.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_input_protect_regs;
    import inprot_pkg::*;
    logic clk_in = 1'b0;
    logic link_clk = 1'b0;
    logic rst_in = 1'b1;
    logic req, wr, wd, done, busy, err, tv = 1'b0, en = 1'b0;
    logic [7:0] cmd;
    logic [15:0] wdat, rdat, vin = 16'h0000, iin = 16'h0000;
    logic conv, alert, alert_oe, fault;
    int miscompares = 0;
    int tests_run = 0;

    always #2 clk_in = ~clk_in;
    // link edges sit on core falling edges, away from core sampling
    always #16 link_clk = ~link_clk;

    input_protect_regs DUT (.clk_in(clk_in), .rst_in(rst_in), .link_clk_in(link_clk),
        .link_req_in(req), .link_cmd_in(cmd), .link_write_in(wr), .link_word_in(wd),
        .link_wdata_in(wdat), .link_done_out(done), .link_busy_out(busy),
        .link_rdata_out(rdat), .link_err_out(err), .nvm_turn_on_in(16'hf015),
        .nvm_ov_limit_in(16'h000c), .nvm_uv_limit_in(16'hf011),
        .nvm_oc_limit_in(16'hf830), .nvm_ocw_limit_in(16'hf812),
        .telem_valid_in(tv), .vin_quarter_in(vin), .iin_half_in(iin),
        .channel_enable_pin_in(en), .host_alert_pin_out(alert),
        .host_alert_pin_oe_out(alert_oe), .regulator_fault_pin_out(fault),
        .conversion_on_out(conv));

    host_model host (.clk_in(link_clk), .busy_in(busy), .done_in(done), .rdata_in(rdat),
        .err_in(err), .req_out(req), .cmd_out(cmd), .write_out(wr), .word_out(wd),
        .wdata_out(wdat));

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [15:0] g, input logic [15:0] x);
        tests_run++;
        if (g !== x) begin
            miscompares++;
            $display("BAD t=%0t got %h exp %h", $time, g, x);
        end
    endtask : chk

    task automatic op(input logic [7:0] c, input logic w, input logic w16,
            input logic [15:0] d, input logic [15:0] x, input logic ee);
        logic [15:0] q;
        logic e;
        bit ok;
        host.xfer(c, w, w16, d, q, e, ok);
        if (!ok) begin
            miscompares++;
            give_verdict();
        end
        chk({15'h0, e}, {15'h0, ee});
        if (!w && !ee) begin
            chk(w16 ? q : {8'h00, q[7:0]}, x);
        end
    endtask : op

    task automatic pins(input logic c, input logic a, input logic f);
        chk({12'h0, conv, alert_oe, fault, alert}, {12'h0, c, a, f, 1'b0});
    endtask : pins

    task automatic tel(input logic [15:0] v, input logic [15:0] i);
        @(posedge clk_in);
        tv <= 1'b1;
        vin <= v;
        iin <= i;
        @(posedge clk_in);
        tv <= 1'b0;
        repeat (3) @(posedge clk_in);
        #1;
    endtask : tel

    task automatic t_reset();
        op(CMD_TURN_ON, 0, 1, 0, 16'hf015, 0);
        op(CMD_OV_LIMIT, 0, 1, 0, 16'h000c, 0);
        op(CMD_UV_LIMIT, 0, 1, 0, 16'hf011, 0);
        op(CMD_OC_LIMIT, 0, 1, 0, 16'hf830, 0);
        op(CMD_OCW_LIMIT, 0, 1, 0, 16'hf87f, 0);
        pins(0, 0, 0);
        $display("reset values done");
    endtask : t_reset

    task automatic t_access();
        op(CMD_OV_ACTION, 0, 0, 0, 16'h0000, 0);
        op(CMD_UV_ACTION, 0, 0, 0, 16'h00c0, 0);
        op(CMD_OC_ACTION, 0, 0, 0, 16'h00c0, 0);
        op(CMD_OV_ACTION, 0, 1, 0, 0, 1);
        op(CMD_UV_ACTION, 1, 0, 16'h00fa, 0, 1);
        op(CMD_OV_LIMIT, 0, 0, 0, 0, 1);
        op(CMD_UV_ACTION, 0, 0, 0, 16'h00c0, 0);
        $display("access sizes done");
    endtask : t_access

    task automatic t_fields();
        op(CMD_TURN_ON, 1, 1, 16'hf021, 0, 0);
        op(CMD_TURN_ON, 0, 1, 0, 16'hf021, 0);
        op(CMD_OV_LIMIT, 1, 1, 16'hf81e, 0, 0);
        op(CMD_OV_LIMIT, 0, 1, 0, 16'h001e, 0);
        op(CMD_UV_LIMIT, 1, 1, 16'hf813, 0, 0);
        op(CMD_UV_LIMIT, 0, 1, 0, 16'hf813, 0);
        op(CMD_OC_LIMIT, 1, 1, 16'h0040, 0, 0);
        op(CMD_OC_LIMIT, 0, 1, 0, 16'hf840, 0);
        op(CMD_OCW_LIMIT, 1, 1, 16'hf830, 0, 0);
        op(CMD_OCW_LIMIT, 0, 1, 0, 16'hf830, 0);
        $display("limit fields done");
    endtask : t_fields

    // turn-on at 33 quarters, undervoltage at 38 quarters
    task automatic t_start_uv();
        @(posedge clk_in);
        en <= 1'b1;
        tel(20, 0);
        pins(0, 0, 0);
        op(CMD_STATUS_INPUT, 0, 0, 0, 16'h0000, 0);
        tel(40, 0);
        pins(1, 0, 0);
        tel(36, 0);
        pins(0, 1, 0);
        op(CMD_STATUS_INPUT, 0, 0, 0, 16'h0010, 0);
        op(CMD_STATUS_BYTE, 0, 0, 0, 16'h0001, 0);
        op(CMD_STATUS_WORD, 0, 1, 0, 16'h2001, 0);
        tel(40, 0);
        pins(1, 1, 0);
        op(CMD_STATUS_INPUT, 1, 0, 16'h00ff, 0, 0);
        tel(40, 0);
        pins(1, 0, 0);
        $display("turn-on and undervoltage done");
    endtask : t_start_uv

    // overvoltage above 30 V, i.e. more than 120 quarters
    task automatic t_ov();
        tel(121, 0);
        pins(1, 1, 0);
        op(CMD_STATUS_INPUT, 0, 0, 0, 16'h0080, 0);
        op(CMD_STATUS_WORD, 0, 1, 0, 16'h2001, 0);
        // telemetry held on, so a sample lands in the clearing cycle
        @(posedge clk_in);
        tv <= 1'b1;
        op(CMD_STATUS_INPUT, 1, 0, 16'h00ff, 0, 0);
        @(posedge clk_in);
        tv <= 1'b0;
        op(CMD_STATUS_INPUT, 0, 0, 0, 16'h0080, 0);
        op(CMD_ALERT_MASK, 1, 0, 16'h0080, 0, 0);
        tel(121, 0);
        pins(1, 0, 0);
        op(CMD_STATUS_INPUT, 0, 0, 0, 16'h0080, 0);
        op(CMD_ALERT_MASK, 1, 0, 16'h00ff, 0, 0);
        tel(121, 49);
        pins(1, 0, 0);
        op(CMD_ALERT_MASK, 0, 0, 0, 16'h00ff, 0);
        op(CMD_ALERT_MASK, 1, 0, 16'h0080, 0, 0);
        op(CMD_STATUS_INPUT, 1, 0, 16'h00ff, 0, 0);
        $display("overvoltage done");
    endtask : t_ov

    // warning above 48 half-amps, fault above 64
    task automatic t_oc();
        tel(40, 49);
        pins(1, 1, 0);
        op(CMD_STATUS_INPUT, 0, 0, 0, 16'h0002, 0);
        op(CMD_STATUS_INPUT, 1, 0, 16'h00ff, 0, 0);
        tel(40, 65);
        pins(0, 1, 1);
        op(CMD_STATUS_INPUT, 0, 0, 0, 16'h0006, 0);
        tel(40, 0);
        chk({15'h0, conv}, 16'h0000);
        op(CMD_OPERATION, 1, 0, 16'h0000, 0, 0);
        op(CMD_OPERATION, 1, 0, 16'h0080, 0, 0);
        op(CMD_STATUS_INPUT, 1, 0, 16'h00ff, 0, 0);
        tel(40, 0);
        pins(1, 0, 0);
        $display("input current done");
    endtask : t_oc

    task automatic t_restore();
        op(CMD_RESTORE, 0, 0, 0, 0, 1);
        op(CMD_RESTORE, 1, 0, 16'h0000, 0, 0);
        op(CMD_OCW_LIMIT, 0, 1, 0, 16'hf87f, 0);
        op(CMD_OC_LIMIT, 0, 1, 0, 16'hf830, 0);
        op(CMD_OV_LIMIT, 0, 1, 0, 16'h000c, 0);
        op(CMD_TURN_ON, 0, 1, 0, 16'hf015, 0);
        $display("restore done");
    endtask : t_restore

    initial begin
        // link sync needs several slow edges, so reset spans link cycles
        repeat (10) @(posedge link_clk);
        @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge link_clk);
        t_reset();
        t_access();
        t_fields();
        t_start_uv();
        t_ov();
        t_oc();
        t_restore();
        give_verdict();
    end
endmodule : test_input_protect_regs
`default_nettype wire
